// ### shared/sps_pkg.sv
package sps_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;            // 100 MHz system clock
  localparam int TICK_NS = 100_000_000;         // 0.1 s timer unit
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int PAUSE_TICKS_DFLT = 1;          // Stop time between steps

  // ----------------------------------------------------------------
  // Limits and codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_INTERNAL = 3'h4;  // Internal multi-speed
  localparam logic [15:0] FREQ_MAX = 16'h9C40;  // 400.00 Hz in 0.01 Hz
  localparam logic [15:0] TMR_MAX = 16'hFDE8;   // 6500.0 s in 0.1 s
  localparam logic [2:0] LAST_STEP = 3'h7;      // Step eight

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_REPEAT = 8'h04;
  localparam logic [7:0] OFS_DIR = 8'h08;
  localparam logic [7:0] OFS_RAMP = 8'h0C;
  localparam logic [7:0] OFS_MAIN = 8'h10;
  localparam logic [7:0] OFS_RESUME = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MEM = 8'h40;       // 32 words up to 8'hBC
  localparam logic [7:0] OFS_MEM_END = 8'hC0;

  // ----------------------------------------------------------------
  // Parameter memory layout (word index)
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_FREQ = 5'h00;      // + step (steps 2..8)
  localparam logic [4:0] IDX_TMR = 5'h08;       // + step (steps 1..8)
  localparam logic [4:0] IDX_RAMP = 5'h10;      // + 2*set, +1 for decel

  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int ST_RUN_BIT = 0;
  localparam int ST_STEP_LSB = 1;
  localparam int ST_HELD_BIT = 4;
  localparam int ST_DONE_BIT = 5;
  localparam int ST_ELAP_LSB = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [1:0] RST_REPEAT = 2'h0;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [15:0] RST_RAMP = 16'h0000;
  localparam logic [15:0] RST_MAIN = 16'h0000;
  localparam logic RST_RESUME = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SQ_IDLE, SQ_F_TMR, SQ_F_FRQ, SQ_F_ACC, SQ_F_DEC, SQ_F_LOAD,
    SQ_RUN, SQ_PAUSE
  } sps_seq_e;

  typedef struct packed {
    logic run;     // Start the program
    logic stop;    // Stop
    logic fault;   // External fault
    logic estop;   // Emergency stop
  } sps_cmd_s;

  typedef struct packed {
    logic run_en;            // Drive running
    logic dir_rev;           // 1 = reverse
    logic [1:0] ramp_sel;    // Ramp set one..four
    logic [15:0] freq;       // 0.01 Hz
    logic [15:0] acc_time;   // Selected acceleration time
    logic [15:0] dec_time;   // Selected deceleration time
    logic step_load;         // New step presented
  } sps_drv_s;

  typedef struct packed {
    logic [2:0] program_mode_select;
    logic [1:0] program_repeat_mode;
    logic [7:0] step_direction_mask;
    logic [15:0] step_ramp_select_word;
    logic [15:0] main_frequency_setpoint;
    logic program_resume_memory;
  } sps_cfg_s;

  typedef struct packed {
    sps_cfg_s cfg;
    logic apb_acc;
    logic [31:0] prdata;
    sps_seq_e seq;
    logic [2:0] step;
    logic [15:0] elapsed;
    logic [31:0] sub;
    logic [15:0] tmr;
    logic [15:0] f_frq;
    logic [15:0] f_acc;
    logic ran_any;
    logic held;
    logic keep;
    logic done;
    sps_drv_s drv;
  } sps_state_s;

endpackage

// ### rtl/sps_param_mem.sv
`timescale 1ns/1ns
module sps_param_mem #(
  parameter int AW = 5,
  parameter int DW = 16
) (
  input wire logic sys_clk,          // System clock
  input wire logic rst_n,            // Synchronous reset
  input wire logic we,               // Write strobe
  input wire logic [AW-1:0] waddr,   // Write index
  input wire logic [DW-1:0] wdata,   // Write data
  input wire logic [AW-1:0] raddr_a, // Bus read index
  output logic [DW-1:0] rdata_a,     // Bus read data, registered
  input wire logic [AW-1:0] raddr_b, // Sequencer read index
  output logic [DW-1:0] rdata_b      // Sequencer read data, registered
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] mem;
    logic [DW-1:0] rd_a;
    logic [DW-1:0] rd_b;
  } sps_mem_s;

  sps_mem_s q;
  sps_mem_s n;

  // Write port and two registered read ports
  always_comb begin
    n = q;
    n.rd_a = q.mem[raddr_a];
    n.rd_b = q.mem[raddr_b];
    if (we) begin
      n.mem[waddr] = wdata;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign rdata_a = q.rd_a;
  assign rdata_b = q.rd_b;

endmodule

// ### rtl/sps_seq_top.sv
// Operation
// - Repeat mode 0 single pass, 1 cycling, 2 and 3 add stops per step.
// - Single pass runs every step once, stops, waits for a new run.
// - Cycling mode advances steps in order and wraps after the last.
// - While running only stop, fault and emergency stop are honoured.
// - Stop-between-steps halts and restarts output at each step change.
// - Step one uses main setpoint, steps two to eight their own.
// - Each step lasts its own timer in 0.1 s units.
// - A step with a zero timer is skipped.
// - Direction mask and ramp word apply only in internal mode 4.
// - All eight step directions sit in one 8-bit mask.
// - Ramp word holds two bits per step, step one lowest.
// - Ramp field 00..11 picks ramp set one..four, accel and decel.
// - Resume setting 1 keeps step and elapsed time across a stop.
`timescale 1ns/1ns
module sps_seq_top #(
  parameter int TICK_CYCLES = sps_pkg::TICK_CYC,
  parameter int PAUSE_TICKS = sps_pkg::PAUSE_TICKS_DFLT
) (
  input wire logic sys_clk,           // System clock, 100 MHz
  input wire logic rst_n,             // Synchronous reset
  input wire logic psel,              // APB select
  input wire logic penable,           // APB enable
  input wire logic pwrite,            // APB direction
  input wire logic [7:0] paddr,       // APB byte address
  input wire logic [31:0] pwdata,     // APB write data
  output logic [31:0] prdata,         // APB read data
  output logic pready,                // APB ready
  output logic pslverr,               // APB error
  input wire sps_pkg::sps_cmd_s cmd,  // Run and stop commands
  output sps_pkg::sps_drv_s drv       // To the ramp generator
);

  // ----------------------------------------------------------------
  // State and memory wiring
  // ----------------------------------------------------------------
  sps_pkg::sps_state_s q;
  sps_pkg::sps_state_s n;
  logic [4:0] addr_b;
  logic [15:0] rd_a;
  logic [15:0] rd_b;
  logic mem_we;
  logic [4:0] mem_idx;
  logic access;
  logic hit_reg;
  logic hit_mem;
  logic kill;
  logic tick;
  logic step_end;
  logic last;
  logic cyc;
  logic gap;
  logic [1:0] ramp_field;
  logic mask_bit;
  logic [15:0] main_lim;
  logic [15:0] elap_inc;

  // Step parameter store
  sps_param_mem #(.AW(5), .DW(16)) u_mem (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .we(mem_we),
    .waddr(mem_idx),
    .wdata(pwdata[15:0]),
    .raddr_a(mem_idx),
    .rdata_a(rd_a),
    .raddr_b(addr_b),
    .rdata_b(rd_b)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign access = psel & penable;
  assign mem_idx = 5'(paddr[7:2] - sps_pkg::OFS_MEM[7:2]);
  assign hit_mem = (paddr >= sps_pkg::OFS_MEM) &&
                   (paddr < sps_pkg::OFS_MEM_END) && (paddr[1:0] == 2'h0);
  assign hit_reg = (paddr == sps_pkg::OFS_MODE) ||
                   (paddr == sps_pkg::OFS_REPEAT) ||
                   (paddr == sps_pkg::OFS_DIR) ||
                   (paddr == sps_pkg::OFS_RAMP) ||
                   (paddr == sps_pkg::OFS_MAIN) ||
                   (paddr == sps_pkg::OFS_RESUME) ||
                   (paddr == sps_pkg::OFS_STATUS);
  // Second access cycle answers; unmapped answers with error
  assign pready = access & q.apb_acc;
  assign pslverr = pready & ~(hit_reg | hit_mem);
  assign mem_we = pready & pwrite & hit_mem;

  // ----------------------------------------------------------------
  // Sequencer helpers
  // ----------------------------------------------------------------
  assign kill = cmd.stop | cmd.fault | cmd.estop |
    (q.cfg.program_mode_select != sps_pkg::MODE_INTERNAL);
  assign tick = (q.sub == 32'(TICK_CYCLES - 1));
  assign elap_inc = q.elapsed + 16'h0001;
  assign step_end = (q.seq == sps_pkg::SQ_RUN) && tick &&
                    (elap_inc >= q.tmr);
  assign last = (q.step == sps_pkg::LAST_STEP);
  assign cyc = q.cfg.program_repeat_mode[0];
  assign gap = q.cfg.program_repeat_mode[1];
  assign ramp_field =
    q.cfg.step_ramp_select_word[{q.step, 1'b0} +: 2];
  assign mask_bit = q.cfg.step_direction_mask[q.step];
  assign main_lim = (q.cfg.main_frequency_setpoint > sps_pkg::FREQ_MAX) ?
    sps_pkg::FREQ_MAX : q.cfg.main_frequency_setpoint;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = q;
    n.drv.step_load = 1'b0;
    addr_b = sps_pkg::IDX_TMR;
    // Bus read capture and register writes
    n.apb_acc = access & ~q.apb_acc;
    if (access && !q.apb_acc) begin
      n.prdata = 32'h0000_0000;
      if (hit_mem) begin
        n.prdata[15:0] = rd_a;
      end else begin
        unique case (paddr)
          sps_pkg::OFS_MODE: n.prdata[2:0] = q.cfg.program_mode_select;
          sps_pkg::OFS_REPEAT: n.prdata[1:0] = q.cfg.program_repeat_mode;
          sps_pkg::OFS_DIR: n.prdata[7:0] = q.cfg.step_direction_mask;
          sps_pkg::OFS_RAMP: n.prdata[15:0] = q.cfg.step_ramp_select_word;
          sps_pkg::OFS_MAIN: n.prdata[15:0] =
            q.cfg.main_frequency_setpoint;
          sps_pkg::OFS_RESUME: n.prdata[0] = q.cfg.program_resume_memory;
          sps_pkg::OFS_STATUS: begin
            n.prdata[sps_pkg::ST_RUN_BIT] = (q.seq != sps_pkg::SQ_IDLE);
            n.prdata[sps_pkg::ST_STEP_LSB +: 3] = q.step;
            n.prdata[sps_pkg::ST_HELD_BIT] = q.held;
            n.prdata[sps_pkg::ST_DONE_BIT] = q.done;
            n.prdata[sps_pkg::ST_ELAP_LSB +: 16] = q.elapsed;
          end
          default: n.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (pready && pwrite) begin
      unique case (paddr)
        sps_pkg::OFS_MODE: n.cfg.program_mode_select = pwdata[2:0];
        sps_pkg::OFS_REPEAT: n.cfg.program_repeat_mode = pwdata[1:0];
        sps_pkg::OFS_DIR: n.cfg.step_direction_mask = pwdata[7:0];
        sps_pkg::OFS_RAMP: n.cfg.step_ramp_select_word = pwdata[15:0];
        sps_pkg::OFS_MAIN: n.cfg.main_frequency_setpoint = pwdata[15:0];
        sps_pkg::OFS_RESUME: n.cfg.program_resume_memory = pwdata[0];
        sps_pkg::OFS_STATUS: begin
          if (pwdata[sps_pkg::ST_DONE_BIT]) begin
            n.done = 1'b0;
          end
        end
        default: n.done = n.done;
      endcase
    end
    // Stop, fault, emergency stop or leaving mode 4 end the run
    if (kill && q.seq != sps_pkg::SQ_IDLE) begin
      n.seq = sps_pkg::SQ_IDLE;
      n.drv.run_en = 1'b0;
      n.keep = 1'b0;
      if (q.cfg.program_resume_memory) begin
        n.held = 1'b1;
        if (q.seq == sps_pkg::SQ_PAUSE) begin
          n.elapsed = 16'h0000;
          n.sub = 32'h0000_0000;
        end
      end else begin
        n.held = 1'b0;
        n.step = 3'h0;
        n.elapsed = 16'h0000;
        n.sub = 32'h0000_0000;
      end
    end else begin
      unique case (q.seq)
        // Wait for a run command; resume or restart from step one
        sps_pkg::SQ_IDLE: begin
          if (cmd.run && !kill) begin
            n.seq = sps_pkg::SQ_F_TMR;
            n.ran_any = 1'b0;
            n.held = 1'b0;
            n.keep = q.held & q.cfg.program_resume_memory;
            if (!(q.held && q.cfg.program_resume_memory)) begin
              n.step = 3'h0;
              n.elapsed = 16'h0000;
              n.sub = 32'h0000_0000;
            end
          end
        end
        // Fetch the step timer
        sps_pkg::SQ_F_TMR: begin
          addr_b = sps_pkg::IDX_TMR + 5'(q.step);
          n.seq = sps_pkg::SQ_F_FRQ;
        end
        // Timer arrives; skip unused steps, else fetch frequency
        sps_pkg::SQ_F_FRQ: begin
          addr_b = sps_pkg::IDX_FREQ + 5'(q.step);
          n.tmr = (rd_b > sps_pkg::TMR_MAX) ? sps_pkg::TMR_MAX : rd_b;
          if (rd_b == 16'h0000) begin
            n.keep = 1'b0;
            n.elapsed = 16'h0000;
            n.sub = 32'h0000_0000;
            if (!last) begin
              n.step = q.step + 3'h1;
              n.seq = sps_pkg::SQ_F_TMR;
            end else if (cyc && q.ran_any) begin
              n.step = 3'h0;
              n.ran_any = 1'b0;
              n.seq = sps_pkg::SQ_F_TMR;
            end else begin
              n.step = 3'h0;
              n.seq = sps_pkg::SQ_IDLE;
              n.drv.run_en = 1'b0;
              n.done = 1'b1;
            end
          end else begin
            n.seq = sps_pkg::SQ_F_ACC;
          end
        end
        // Frequency arrives; step one takes the main setpoint
        sps_pkg::SQ_F_ACC: begin
          addr_b = sps_pkg::IDX_RAMP + 5'({ramp_field, 1'b0});
          if (q.step == 3'h0) begin
            n.f_frq = main_lim;
          end else begin
            n.f_frq = (rd_b > sps_pkg::FREQ_MAX) ? sps_pkg::FREQ_MAX :
                      rd_b;
          end
          n.seq = sps_pkg::SQ_F_DEC;
        end
        // Acceleration time arrives
        sps_pkg::SQ_F_DEC: begin
          addr_b = sps_pkg::IDX_RAMP + 5'({ramp_field, 1'b1});
          n.f_acc = rd_b;
          n.seq = sps_pkg::SQ_F_LOAD;
        end
        // Present the whole step at once
        sps_pkg::SQ_F_LOAD: begin
          n.drv.freq = q.f_frq;
          n.drv.dir_rev = mask_bit;
          n.drv.ramp_sel = ramp_field;
          n.drv.acc_time = q.f_acc;
          n.drv.dec_time = rd_b;
          n.drv.run_en = 1'b1;
          n.drv.step_load = 1'b1;
          n.ran_any = 1'b1;
          n.keep = 1'b0;
          n.seq = sps_pkg::SQ_RUN;
          if (!q.keep) begin
            n.elapsed = 16'h0000;
            n.sub = 32'h0000_0000;
          end
        end
        // Count 0.1 s ticks until the step timer expires
        sps_pkg::SQ_RUN: begin
          n.sub = q.sub + 32'h0000_0001;
          if (tick) begin
            n.sub = 32'h0000_0000;
            n.elapsed = elap_inc;
          end
          if (step_end) begin
            n.elapsed = 16'h0000;
            if (last && !cyc) begin
              n.seq = sps_pkg::SQ_IDLE;
              n.step = 3'h0;
              n.drv.run_en = 1'b0;
              n.done = 1'b1;
            end else begin
              n.step = last ? 3'h0 : q.step + 3'h1;
              if (last) begin
                n.ran_any = 1'b0;
              end
              if (gap) begin
                n.seq = sps_pkg::SQ_PAUSE;
                n.drv.run_en = 1'b0;
              end else begin
                n.seq = sps_pkg::SQ_F_TMR;
              end
            end
          end
        end
        // Output held stopped before the next step restarts it
        sps_pkg::SQ_PAUSE: begin
          n.sub = q.sub + 32'h0000_0001;
          if (tick) begin
            n.sub = 32'h0000_0000;
            n.elapsed = elap_inc;
            if (elap_inc >= 16'(PAUSE_TICKS)) begin
              n.elapsed = 16'h0000;
              n.seq = sps_pkg::SQ_F_TMR;
            end
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.cfg.program_mode_select <= sps_pkg::RST_MODE;
      q.cfg.program_repeat_mode <= sps_pkg::RST_REPEAT;
      q.cfg.step_direction_mask <= sps_pkg::RST_DIR;
      q.cfg.step_ramp_select_word <= sps_pkg::RST_RAMP;
      q.cfg.main_frequency_setpoint <= sps_pkg::RST_MAIN;
      q.cfg.program_resume_memory <= sps_pkg::RST_RESUME;
      q.seq <= sps_pkg::SQ_IDLE;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign drv = q.drv;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_kill_stops: assert property (
    kill && q.seq != sps_pkg::SQ_IDLE |=>
      q.seq == sps_pkg::SQ_IDLE && !q.drv.run_en)
    else $error("stop command did not halt the program");

  a_run_ignored: assert property (
    q.seq == sps_pkg::SQ_RUN && cmd.run && !kill && !tick |=>
      $stable(q.step) && $stable(q.elapsed))
    else $error("run command disturbed a running program");

  a_mode_gate: assert property (
    q.cfg.program_mode_select != sps_pkg::MODE_INTERNAL |=>
      !q.drv.run_en)
    else $error("program runs outside internal mode");

  a_dir_map: assert property (
    q.drv.step_load |-> q.drv.dir_rev == $past(mask_bit))
    else $error("step direction does not follow its mask bit");

  a_ramp_pick: assert property (
    q.drv.step_load |->
      q.drv.ramp_sel == $past(ramp_field) && q.drv.run_en)
    else $error("ramp set does not follow the step field");

  a_main_step: assert property (
    q.drv.step_load && q.step == 3'h0 |-> q.drv.freq == $past(main_lim, 3))
    else $error("step one frequency is not the main setpoint");

  a_skip_zero: assert property (
    q.drv.step_load |-> q.tmr != 16'h0000)
    else $error("a step with zero timer was run");

  a_tick_count: assert property (
    q.seq == sps_pkg::SQ_RUN && tick && !kill && !step_end |=>
      q.elapsed == $past(q.elapsed) + 16'h0001)
    else $error("step time did not advance on a tick");

  a_single_end: assert property (
    step_end && last && q.cfg.program_repeat_mode == 2'h0 && !kill |=>
      q.seq == sps_pkg::SQ_IDLE && q.done)
    else $error("single pass did not stop after the last step");

  a_cycle_wrap: assert property (
    step_end && last && q.cfg.program_repeat_mode == 2'h1 && !kill |=>
      q.step == 3'h0 && q.seq == sps_pkg::SQ_F_TMR)
    else $error("cycling mode did not wrap to step one");

  a_step_pause: assert property (
    step_end && gap && !(last && !cyc) && !kill |=> !q.drv.run_en [*2])
    else $error("output not stopped between steps");

  a_resume_hold: assert property (
    kill && q.cfg.program_resume_memory && q.seq == sps_pkg::SQ_RUN |=>
      $stable(q.step) && $stable(q.elapsed) && q.held)
    else $error("resume did not keep step and time");

endmodule

// ### verif/sps_ramp_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Ramp generator seen from the sequencer
// ----------------------------------------------------------------
module sps_ramp_model (
  input wire logic sys_clk,          // System clock
  input wire logic rst_n,            // Synchronous reset
  input wire sps_pkg::sps_drv_s drv, // Step presented by the sequencer
  output logic [7:0] load_cnt,       // Steps taken over
  output logic [15:0] target_freq    // Frequency being ramped to
);
  // Take over frequency and count the step only on a load pulse
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      load_cnt <= 8'h00;
      target_freq <= 16'h0000;
    end else if (drv.step_load) begin
      load_cnt <= load_cnt + 8'h01;
      target_freq <= drv.freq;
    end
  end
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0, load_cnt, dirm;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er;
  logic [15:0] mem [32], rw, mainf, tf;
  sps_pkg::sps_cmd_s cmd = '0;
  sps_pkg::sps_drv_s drv;
  int miscompares = 0, n_checks = 0, cyc = 0, k, f, c0, lo;

  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  always #5 sys_clk = ~sys_clk;
  sps_seq_top #(.TICK_CYCLES(2)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd(cmd), .drv(drv));
  sps_ramp_model ramp_u (.sys_clk(sys_clk), .rst_n(rst_n), .drv(drv),
    .load_cnt(load_cnt), .target_freq(tf));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task chk(input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task finish_test;
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // One APB transfer, held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Wait for a step load, noting whether the drive stopped meanwhile
  task wait_load(output int low);
    int n;
    n = 0;
    low = 0;
    @(posedge sys_clk);
    while (drv.step_load !== 1'b1 && n < 300) begin
      if (drv.run_en !== 1'b1) low = 1;
      @(posedge sys_clk);
      n++;
    end
    if (n >= 300) miscompares++;
  endtask

  task pulse_run;
    @(posedge sys_clk);
    cmd.run <= 1'b1;
    @(posedge sys_clk);
    cmd.run <= 1'b0;
  endtask

  // Next used step after s, or -1 past the last
  function automatic int nxt(int s);
    for (int i = s + 1; i < 8; i++) if (mem[8 + i] != 0) return i;
    return -1;
  endfunction

  // Drive values expected when step s is presented
  function automatic logic [63:0] exp_drv(int s);
    sps_pkg::sps_drv_s e;
    e.run_en = 1'b1;
    e.step_load = 1'b1;
    e.dir_rev = dirm[s];
    e.ramp_sel = rw[2 * s +: 2];
    e.freq = (s == 0) ? mainf : mem[s];
    if (e.freq > sps_pkg::FREQ_MAX) e.freq = sps_pkg::FREQ_MAX;
    e.acc_time = mem[16 + 2 * e.ramp_sel];
    e.dec_time = mem[17 + 2 * e.ramp_sel];
    return 64'(e);
  endfunction

  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 20000) begin
      miscompares++;
      finish_test;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h0340_73c2));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    apb(1'b0, sps_pkg::OFS_DIR, '0);
    chk(rd, 0);
    apb(1'b1, 8'h30, 32'h0000_00ff);
    chk(er, 1);
    apb(1'b0, 8'h30, '0);
    chk({er, rd}, {1'b1, 32'h0000_0000});
    for (int i = 0; i < 32; i++) mem[i] = 16'($urandom_range(40000));
    for (int i = 8; i < 16; i++) mem[i] = 16'($urandom_range(2));
    mem[8] = 16'h0001;
    mem[15] = 16'h0001;
    mem[11] = 16'h0001;
    mem[12] = 16'h0000;
    mem[3] = 16'hffff;
    dirm = 8'($urandom);
    rw = 16'($urandom);
    mainf = 16'($urandom_range(40000));
    for (int i = 0; i < 32; i++) apb(1'b1, 8'(8'h40 + 4 * i), 32'(mem[i]));
    apb(1'b1, sps_pkg::OFS_DIR, 32'(dirm));
    apb(1'b1, sps_pkg::OFS_RAMP, 32'(rw));
    apb(1'b1, sps_pkg::OFS_MAIN, 32'(mainf));
    apb(1'b0, sps_pkg::OFS_RAMP, '0);
    chk(rd, {16'h0000, rw});
    // Run refused outside internal multi-speed mode
    apb(1'b1, sps_pkg::OFS_MODE, 32'h0000_0002);
    pulse_run;
    repeat (20) @(posedge sys_clk);
    chk(drv.run_en, 0);
    apb(1'b1, sps_pkg::OFS_MODE, 32'h0000_0004);
    // Single pass, plain and with stops between steps
    for (int r = 0; r < 4; r += 2) begin
      apb(1'b1, sps_pkg::OFS_REPEAT, 32'(r));
      c0 = load_cnt;
      f = 0;
      pulse_run;
      for (k = nxt(-1); k >= 0; k = nxt(k)) begin
        wait_load(lo);
        f++;
        chk(drv, exp_drv(k));
        if (k != 0) chk(lo, r[1]);
      end
      repeat (20) @(posedge sys_clk);
      chk(drv.run_en, 0);
      chk(tf, (mem[7] > sps_pkg::FREQ_MAX) ?
        sps_pkg::FREQ_MAX : mem[7]);
      chk(8'(load_cnt - c0), f);
      apb(1'b0, sps_pkg::OFS_STATUS, '0);
      chk(rd[5], 1);
      apb(1'b1, sps_pkg::OFS_STATUS, 32'h0000_0020);
    end
    // Cycling with run held, then stop, fault and emergency stop
    k = nxt(-1);
    for (int j = 0; j < 3; j++) begin
      // Last round resumes the held step, with stops between steps
      apb(1'b1, sps_pkg::OFS_REPEAT, 32'((j == 2) ? 3 : 1));
      apb(1'b1, sps_pkg::OFS_RESUME, 32'(j != 0));
      cmd <= 4'b1000;
      for (int i = 0; i < 9; i++) begin
        wait_load(lo);
        chk(drv, exp_drv(k));
        if (i > 0) chk(lo, j == 2);
        if (i < 8) k = (nxt(k) < 0) ? nxt(-1) : nxt(k);
      end
      cmd <= 4'(4'b0100 >> j);
      repeat (3) @(posedge sys_clk);
      chk(drv.run_en, 0);
      cmd <= '0;
      if (j != 1) k = nxt(-1);
      repeat (3) @(posedge sys_clk);
    end
    finish_test;
  end
endmodule
